// *** rtl/swc_sleep_wake.sv ***
/*
 * sleep/wake controller: halt entry, wake detection, oscillator start-up
 * wait, watchdog with prescaler, status flags, register port.
 * assumes the core pulses i_halt_exec / i_wdclr_exec for one cycle and
 * follows o_core_clk_en, o_resume, o_vector_req and o_core_reset.
 */
`timescale 1ns/1ps
module swc_sleep_wake
	import swc_pkg::*;
#(
	parameter int WD_BASE = SWC_WD_BASE
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [15:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// core side
	input wire logic i_halt_exec,
	input wire logic i_wdclr_exec,
	input wire logic i_external_reset_pin_n,
	input wire logic i_edge_irq_flag,
	input wire logic i_port_irq_flag,
	input wire logic i_mem_irq_flag,
	input wire logic i_timer_irq_flag,
	input wire logic [12:0] i_pc,
	output logic o_core_clk_en,
	output logic o_prefetch_req,
	output logic [12:0] o_prefetch_addr,
	output logic o_resume,
	output logic o_vector_req,
	output logic [12:0] o_vector_addr,
	output logic o_core_reset,
	output logic o_external_reset_pin_oe,
	output logic o_pin_hold,
	output logic o_periph_irq_gate
);

	////////////////////////////////////////////////////////////////
	typedef enum {ST_RUN, ST_SLEEP, ST_OST, ST_WAKE} swc_state_e;

	typedef struct packed {
		swc_state_e st;
		logic [7:0] option;
		logic [7:0] intctl;
		logic pd;
		logic to;
		logic [31:0] wd_cnt;
		logic [7:0] ps_cnt;
		logic [10:0] ost_cnt;
		logic ack;
		logic [31:0] rdat;
		logic pf_req;
		logic [12:0] pf_addr;
		logic resume;
		logic vec;
		logic rst;
	} swc_s;

	swc_s state_reg, state_next;
	logic [7:0] config_word; // fuses, fixed at build
	logic [3:0] enabled_pend; // flag and own enable
	logic any_wake_irq;
	logic pin_reset;
	logic wd_timeout;
	logic [31:0] wd_limit;
	logic [13:0] idx;
	logic hit;

	assign config_word = SWC_CONFIG_RST;

	////////////////////////////////////////////////////////////////
	// wake sources, individual enables only
	always_comb begin
		enabled_pend[0] = i_edge_irq_flag & state_reg.intctl[SWC_IC_EDGE_EN];
		enabled_pend[1] = i_port_irq_flag & state_reg.intctl[SWC_IC_PORT_EN];
		enabled_pend[2] = i_mem_irq_flag & state_reg.intctl[SWC_IC_MEM_EN];
		// timer is q-clock based, so it cannot wake
		enabled_pend[3] = 1'b0;
		any_wake_irq = |enabled_pend;
		pin_reset = ~i_external_reset_pin_n;
		// prescaler assigned to watchdog stretches the period
		if (state_reg.option[SWC_OP_PSA])
			wd_limit = WD_BASE << state_reg.option[2:0];
		else
			wd_limit = WD_BASE;
		wd_timeout = config_word[SWC_CF_WATCHDOG_ENABLE_FUSE] &&
			(state_reg.wd_cnt >= wd_limit - 32'h1);
		idx = i_wb_adr[15:2];
		hit = (idx == SWC_IDX_OPTION) || (idx == SWC_IDX_CONFIG) ||
			(idx == SWC_IDX_STATUS) || (idx == SWC_IDX_INTCTL) ||
			(idx == SWC_IDX_WDCNT);
	end

	////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		state_next = state_reg;
		state_next.pf_req = 1'b0;
		state_next.resume = 1'b0;
		state_next.vec = 1'b0;
		state_next.rst = 1'b0;
		state_next.ack = 1'b0;
		// watchdog runs from its own oscillator, also asleep
		if (config_word[SWC_CF_WATCHDOG_ENABLE_FUSE])
			state_next.wd_cnt = state_reg.wd_cnt + 32'h1;
		// register port: single-cycle ack, none while acking
		if (i_wb_cyc && i_wb_stb && !state_reg.ack) begin
			state_next.ack = 1'b1;
			state_next.rdat = 32'h0;
			case (idx)
				SWC_IDX_OPTION: state_next.rdat[7:0] = state_reg.option;
				SWC_IDX_CONFIG: state_next.rdat[7:0] = config_word;
				SWC_IDX_STATUS: begin
					state_next.rdat[SWC_ST_PD] = state_reg.pd;
					state_next.rdat[SWC_ST_TO] = state_reg.to;
				end
				SWC_IDX_INTCTL: state_next.rdat[7:0] = state_reg.intctl;
				SWC_IDX_WDCNT: state_next.rdat = state_reg.wd_cnt;
				default: state_next.rdat = 32'h0;
			endcase
			if (i_wb_we && i_wb_sel[0] && hit) begin
				if (idx == SWC_IDX_OPTION)
					state_next.option = i_wb_dat[7:0];
				if (idx == SWC_IDX_INTCTL)
					state_next.intctl = i_wb_dat[7:0];
			end
		end
		// clear instruction clears count and prescaler
		if (i_wdclr_exec) begin
			state_next.wd_cnt = 32'h0;
			state_next.ps_cnt = 8'h0;
		end
		case (state_reg.st)
			ST_RUN: begin
				// halt is the only way
				if (i_halt_exec) begin
					state_next.pf_req = 1'b1;
					state_next.pf_addr = i_pc + 13'h1;
					if (any_wake_irq &&
						!state_reg.intctl[SWC_IC_GIE]) begin
						// halt completes as a nop
						state_next.resume = 1'b1;
					end else begin
						state_next.wd_cnt = 32'h0;
						state_next.ps_cnt = 8'h0;
						state_next.pd = 1'b0;
						state_next.to = 1'b1;
						state_next.st = ST_SLEEP;
					end
				end else if (wd_timeout) begin
					// awake timeout resets, pin left alone
					state_next.to = 1'b0;
					state_next.wd_cnt = 32'h0;
					state_next.rst = 1'b1;
				end
			end
			ST_SLEEP: begin
				// enabled interrupt wakes at once after halt
				if (wd_timeout || any_wake_irq) begin
					if (wd_timeout) begin
						state_next.to = 1'b0;
						state_next.wd_cnt = 32'h0;
					end
					state_next.ost_cnt = 11'h0;
					// rc mode skips the start-up delay
					if (config_word[SWC_CF_OSC_HI:SWC_CF_OSC_LO] ==
						SWC_OSC_RC)
						state_next.st = ST_WAKE;
					else
						state_next.st = ST_OST;
				end
			end
			ST_OST: begin
				// count oscillator periods before release
				state_next.ost_cnt = state_reg.ost_cnt + 11'h1;
				if (state_reg.ost_cnt == 11'(SWC_OST_CYCLES - 1))
					state_next.st = ST_WAKE;
			end
			ST_WAKE: begin
				// run next instruction, then vector if enabled
				state_next.resume = 1'b1;
				state_next.vec = state_reg.intctl[SWC_IC_GIE];
				state_next.st = ST_RUN;
			end
			default: state_next.st = ST_RUN;
		endcase
		// reset pin wake is a full reset, to set, pd set only if running
		if (pin_reset) begin
			state_next.st = ST_RUN;
			state_next.rst = 1'b1;
			state_next.option = SWC_OPTION_RST;
			state_next.intctl = 8'h0;
			state_next.wd_cnt = 32'h0;
			state_next.ost_cnt = 11'h0;
			if (state_reg.st == ST_RUN)
				state_next.pd = 1'b1;
			state_next.to = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// state register; power-on sets both flags
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			state_reg <= '{st: ST_RUN, option: SWC_OPTION_RST,
				intctl: 8'h0, pd: 1'b1, to: 1'b1, wd_cnt: 32'h0,
				ps_cnt: 8'h0, ost_cnt: 11'h0, ack: 1'b0,
				rdat: 32'h0, pf_req: 1'b0, pf_addr: 13'h0,
				resume: 1'b0, vec: 1'b0, rst: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs
	assign o_wb_ack = state_reg.ack;
	assign o_wb_dat = state_reg.rdat;
	// core clock stays gated until wake and delay done
	assign o_core_clk_en = (state_reg.st == ST_RUN);
	assign o_prefetch_req = state_reg.pf_req;
	assign o_prefetch_addr = state_reg.pf_addr;
	assign o_resume = state_reg.resume;
	assign o_vector_req = state_reg.vec;
	assign o_vector_addr = SWC_IRQ_VECTOR;
	assign o_core_reset = state_reg.rst;
	// never drive the reset pin
	assign o_external_reset_pin_oe = 1'b0;
	// pin drivers freeze while not running
	assign o_pin_hold = (state_reg.st != ST_RUN);
	// q-clock peripherals cannot raise interrupts asleep
	assign o_periph_irq_gate = (state_reg.st == ST_RUN);

	////////////////////////////////////////////////////////////////
	// checks
	property p_halt_sleep;
		@(posedge i_clk_sys) disable iff (i_reset)
		(state_reg.st == ST_RUN && i_halt_exec && !pin_reset &&
		 !(any_wake_irq && !state_reg.intctl[SWC_IC_GIE]))
		|=> (!state_reg.pd && state_reg.to && !o_core_clk_en);
	endproperty
	a_halt_sleep: assert property (p_halt_sleep)
		else $error("halt did not enter sleep");

	property p_halt_nop;
		@(posedge i_clk_sys) disable iff (i_reset)
		(state_reg.st == ST_RUN && i_halt_exec && !pin_reset &&
		 any_wake_irq && !state_reg.intctl[SWC_IC_GIE])
		|=> (o_core_clk_en && $stable(state_reg.pd) && o_resume);
	endproperty
	a_halt_nop: assert property (p_halt_nop)
		else $error("pending halt not a nop");

	property p_pin_never;
		@(posedge i_clk_sys) disable iff (i_reset)
		!o_external_reset_pin_oe;
	endproperty
	a_pin_never: assert property (p_pin_never)
		else $error("reset pin driven");

	property p_only_halt;
		@(posedge i_clk_sys) disable iff (i_reset)
		(state_reg.st == ST_RUN && !i_halt_exec) |=> o_core_clk_en;
	endproperty
	a_only_halt: assert property (p_only_halt)
		else $error("sleep without halt");

	property p_ost_len;
		@(posedge i_clk_sys) disable iff (i_reset || pin_reset)
		(state_reg.st == ST_SLEEP && any_wake_irq &&
		 state_next.st == ST_OST) |=> !o_core_clk_en [*8];
	endproperty
	a_ost_len: assert property (p_ost_len)
		else $error("start-up delay cut short");

	property p_prefetch;
		@(posedge i_clk_sys) disable iff (i_reset)
		(state_reg.st == ST_RUN && i_halt_exec && !pin_reset)
		|=> (o_prefetch_req && o_prefetch_addr == $past(i_pc) + 13'h1);
	endproperty
	a_prefetch: assert property (p_prefetch)
		else $error("no prefetch of next address");

	property p_vec;
		@(posedge i_clk_sys) disable iff (i_reset)
		o_vector_req |-> ($past(state_reg.st) == ST_WAKE &&
			o_resume && o_vector_addr == 13'h0004);
	endproperty
	a_vec: assert property (p_vec)
		else $error("vector outside wake");

	property p_pin_wake;
		@(posedge i_clk_sys) disable iff (i_reset)
		(state_reg.st == ST_SLEEP && pin_reset)
		|=> (o_core_reset && !state_reg.pd && state_reg.to);
	endproperty
	a_pin_wake: assert property (p_pin_wake)
		else $error("pin wake not a reset");

	property p_wd_awake;
		@(posedge i_clk_sys) disable iff (i_reset)
		(state_reg.st == ST_RUN && wd_timeout && !i_halt_exec &&
		 !pin_reset) |=> (o_core_reset && !state_reg.to);
	endproperty
	a_wd_awake: assert property (p_wd_awake)
		else $error("awake watchdog timeout missed");

	property p_hold;
		@(posedge i_clk_sys) disable iff (i_reset)
		(state_reg.st == ST_SLEEP) |-> (o_pin_hold && !o_periph_irq_gate);
	endproperty
	a_hold: assert property (p_hold)
		else $error("pins not held in sleep");
endmodule

// *** rtl/swc_pkg.sv ***
/*
 * package for the sleep/wake controller: register map, field positions,
 * reset values and timing constants.
 * assumes a 10 MHz system clock and a classic wishbone register port.
 */
package swc_pkg;
	// register word offsets (byte address = 4 * index)
	localparam logic [13:0] SWC_IDX_OPTION = 14'h0081;
	localparam logic [13:0] SWC_IDX_CONFIG = 14'h2007;
	localparam logic [13:0] SWC_IDX_STATUS = 14'h0003;
	localparam logic [13:0] SWC_IDX_INTCTL = 14'h000B;
	localparam logic [13:0] SWC_IDX_WDCNT = 14'h0010;
	// reset values
	localparam logic [7:0] SWC_OPTION_RST = 8'hFF;
	localparam logic [7:0] SWC_CONFIG_RST = 8'h0F;
	// status fields
	localparam int SWC_ST_PD = 3;
	localparam int SWC_ST_TO = 4;
	// config fields
	localparam int SWC_CF_OSC_LO = 0;
	localparam int SWC_CF_OSC_HI = 1;
	localparam int SWC_CF_WATCHDOG_ENABLE_FUSE = 2;
	// option fields
	localparam int SWC_OP_PSA = 3;
	// interrupt control fields: enables 6, 4 and 3, global 7
	localparam int SWC_IC_GIE = 7;
	localparam int SWC_IC_EDGE_EN = 4;
	localparam int SWC_IC_PORT_EN = 3;
	localparam int SWC_IC_MEM_EN = 6;
	// rc oscillator mode code
	localparam logic [1:0] SWC_OSC_RC = 2'h3;
	// interrupt vector
	localparam logic [12:0] SWC_IRQ_VECTOR = 13'h0004;
	// oscillator start-up delay, in oscillator periods
	localparam int SWC_OST_PERIODS = 1024;
	localparam int SWC_CLK_NS = 100;
	localparam int SWC_OST_CYCLES = SWC_OST_PERIODS;
	// watchdog base period in system cycles (shortened by parameter)
	localparam int SWC_WD_BASE = 180000;
endpackage

// *** sim/swc_core_model.sv ***
/*
 * core-side partner: halt and watchdog-clear pulses, program counter,
 * interrupt source flags and the external reset pin.
 * assumes the bench calls its tasks; all changes land on rising edges.
 */
`timescale 1ns/1ps
module swc_core_model (
	// clock
	input wire logic i_clk,
	// towards the controller
	output logic o_halt,
	output logic o_wdclr,
	output logic [2:0] o_flags,
	output logic o_pin_n,
	output logic [12:0] o_pc
);
	// idle: no pulses, pin released high by its pull-up
	initial begin
		o_halt = 1'b0;
		o_wdclr = 1'b0;
		o_flags = 3'h0;
		o_pin_n = 1'b1;
		o_pc = 13'h0000;
	end
	////////////////////////////////////////////////////////////////////
	// one-cycle strobe, halt or watchdog clear
	task pulse(input logic h);
		@(posedge i_clk);
		if (h) begin
			o_halt <= 1'b1;
		end else begin
			o_wdclr <= 1'b1;
		end
		@(posedge i_clk);
		o_halt <= 1'b0;
		o_wdclr <= 1'b0;
	endtask
	// clear first so a stale count cannot fire before the halt is taken
	task sleep(input logic [12:0] pc);
		pulse(1'b0);
		o_pc <= pc; // word after pc is a nop slot in the program
		pulse(1'b1);
	endtask
	// flags {edge, port, mem} and the pin level
	task setf(input logic [2:0] f, input logic pin);
		@(posedge i_clk);
		o_flags <= f;
		o_pin_n <= pin;
	endtask
endmodule

// *** sim/tb_top.sv ***
/*
 * bench for the sleep/wake controller: register port, halt, wake paths.
 * assumes the controller answers status reads over wishbone while asleep.
 */
`timescale 1ns/1ps
`define CK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
	$display("BAD t=%0t got %0h exp %0h", $time, (a), (b)); end end
`define WT(c, n) #1; for (k = 0; k < (n) && !(c); k++) begin \
	@(posedge i_clk_sys); #1; end if (k >= (n)) timeout();
module tb_top;
	import swc_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_reset = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [15:0] adr = 16'h0000;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic ack, clk_en, pf_req, resume, vec_req, core_rst, pin_oe, hold, gate;
	logic [12:0] pf_addr, vec_addr, pc;
	logic halt, wdclr, pin_n;
	logic [3:0] sel = 4'hF;
	logic tfl = 1'b0;
	logic [2:0] fl;
	int n_mismatch = 0, compares = 0, k, n_rst = 0;
	always #50 i_clk_sys = ~i_clk_sys;
	// internal resets seen so far
	always @(posedge i_clk_sys) if (core_rst === 1'b1) n_rst++;
	swc_core_model core (.i_clk(i_clk_sys), .o_halt(halt), .o_wdclr(wdclr),
		.o_flags(fl), .o_pin_n(pin_n), .o_pc(pc));
	// short watchdog period keeps the run brief
	swc_sleep_wake #(.WD_BASE(50)) dut (.i_clk_sys(i_clk_sys),
		.i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_halt_exec(halt), .i_wdclr_exec(wdclr),
		.i_external_reset_pin_n(pin_n), .i_edge_irq_flag(fl[2]),
		.i_port_irq_flag(fl[1]), .i_mem_irq_flag(fl[0]),
		.i_timer_irq_flag(tfl), .i_pc(pc), .o_core_clk_en(clk_en),
		.o_prefetch_req(pf_req), .o_prefetch_addr(pf_addr),
		.o_resume(resume), .o_vector_req(vec_req),
		.o_vector_addr(vec_addr), .o_core_reset(core_rst),
		.o_external_reset_pin_oe(pin_oe), .o_pin_hold(hold),
		.o_periph_irq_gate(gate));
	////////////////////////////////////////////////////////////////////
	task report_and_stop;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task timeout;
		n_mismatch++;
		report_and_stop();
	endtask
	// classic cycle: hold until ack is sampled, then release
	task wb(input logic w, input logic [13:0] idx, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge i_clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= d;
		do begin
			@(posedge i_clk_sys);
			i++;
		end while (ack !== 1'b1 && i < 20);
		q = rdat;
		if (ack !== 1'b1) timeout();
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	// status flags as {timeout, powerdown}
	task st(input logic [1:0] e);
		wb(1'b0, SWC_IDX_STATUS, 32'h0);
		`CK(q[4:3], e)
	endtask
	////////////////////////////////////////////////////////////////////
	task t_regs;
		wb(1'b0, SWC_IDX_OPTION, 32'h0);
		`CK(q, 32'h000000FF)
		wb(1'b0, SWC_IDX_CONFIG, 32'h0);
		`CK(q, 32'h0000000F)
		st(2'b11);
		wb(1'b0, 14'h0555, 32'h0);
		`CK(q, 32'h0)
		wb(1'b1, SWC_IDX_OPTION, 32'hAF);
		wb(1'b0, SWC_IDX_OPTION, 32'h0);
		`CK(q, 32'h000000AF)
		// write with low byte lane off is ignored
		@(posedge i_clk_sys);
		sel <= 4'h0;
		wb(1'b1, SWC_IDX_OPTION, 32'h55);
		sel <= 4'hF;
		wb(1'b0, SWC_IDX_OPTION, 32'h0);
		`CK(q, 32'h000000AF)
		wb(1'b1, SWC_IDX_CONFIG, 32'h0);
		wb(1'b0, SWC_IDX_CONFIG, 32'h0);
		`CK(q, 32'h0000000F)
		$display("t_regs done");
	endtask
	task t_sleep_int;
		wb(1'b1, SWC_IDX_INTCTL, 32'h10);
		core.sleep(13'h123);
		#1;
		`CK(pf_req, 1'b1)
		`CK(pf_addr, 13'h124)
		`CK(clk_en, 1'b0)
		`CK(hold, 1'b1)
		`CK(gate, 1'b0)
		st(2'b10);
		core.setf(3'b010, 1'b1);
		tfl <= 1'b1;
		repeat (20) @(posedge i_clk_sys);
		#1;
		`CK(clk_en, 1'b0)
		core.setf(3'b100, 1'b1);
		`WT(resume === 1'b1, 20)
		`CK(k < 8, 1'b1)
		`CK(vec_req, 1'b0)
		`CK(core_rst, 1'b0)
		core.setf(3'b000, 1'b1);
		tfl <= 1'b0;
		#1;
		`CK(clk_en, 1'b1)
		$display("t_sleep_int done");
	endtask
	task t_vec;
		wb(1'b1, SWC_IDX_INTCTL, 32'hC0);
		core.sleep(13'h050);
		core.setf(3'b001, 1'b1);
		`WT(resume === 1'b1, 20)
		`CK(k < 8, 1'b1)
		`CK(vec_req, 1'b1)
		`CK(vec_addr, 13'h0004)
		core.setf(3'b000, 1'b1);
		st(2'b10);
		$display("t_vec done");
	endtask
	task t_pin;
		// pin low for one cycle only, so it is seen once
		core.sleep(13'h040);
		core.setf(3'b000, 1'b0);
		core.setf(3'b000, 1'b1);
		`WT(core_rst === 1'b1, 4)
		`CK(core_rst, 1'b1)
		st(2'b10);
		core.setf(3'b000, 1'b0);
		core.setf(3'b000, 1'b1);
		`WT(core_rst === 1'b1, 4)
		st(2'b11);
		$display("t_pin done");
	endtask
	task t_nop;
		wb(1'b1, SWC_IDX_INTCTL, 32'h10);
		core.setf(3'b100, 1'b1);
		core.sleep(13'h200);
		`WT(resume === 1'b1, 4)
		`CK(clk_en, 1'b1)
		core.setf(3'b000, 1'b1);
		st(2'b11);
		$display("t_nop done");
	endtask
	task t_wdt;
		int r;
		core.pulse(1'b0);
		wb(1'b1, SWC_IDX_OPTION, 32'h00);
		`WT(core_rst === 1'b1, 200)
		`CK(pin_oe, 1'b0)
		`CK(clk_en, 1'b1)
		st(2'b01);
		wb(1'b1, SWC_IDX_OPTION, 32'h00);
		r = n_rst;
		repeat (8) begin
			core.pulse(1'b0);
			repeat (15) @(posedge i_clk_sys);
		end
		`CK(n_rst, r)
		core.sleep(13'h300);
		`WT(resume === 1'b1, 300)
		`CK(n_rst, r)
		st(2'b00);
		$display("t_wdt done");
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		t_regs();
		t_sleep_int();
		t_vec();
		t_pin();
		t_nop();
		t_wdt();
		report_and_stop();
	end
endmodule
